// ### src/arc_pkg.sv
/*
 * arc_pkg: register map, field positions, reset values and decoded
 * control types for the analog reference control block.
 * Assumes a 32-bit AXI4-Lite register bus; 8-bit registers sit in the
 * low byte of each word.
 */
package arc_pkg;

    // register byte offsets
    localparam logic [3:0] ARC_OFS_FIXED_REF   = 4'h0;
    localparam logic [3:0] ARC_OFS_LADDER_CTL  = 4'h4;
    localparam logic [3:0] ARC_OFS_LADDER_LVL  = 4'h8;
    localparam int         ARC_ADDR_W          = 4;

    // fixed reference control fields
    localparam int ARC_FR_ON_BIT    = 7;
    localparam int ARC_FR_RDY_BIT   = 6;
    localparam int ARC_FR_TS_BIT    = 5;
    localparam int ARC_FR_RNG_BIT   = 4;
    localparam int ARC_FR_CMP_LSB   = 2;
    localparam int ARC_FR_CNV_LSB   = 0;

    // ladder control fields
    localparam int ARC_LC_ON_BIT    = 7;
    localparam int ARC_LC_P1_BIT    = 5;
    localparam int ARC_LC_P2_BIT    = 4;
    localparam int ARC_LC_UP_LSB    = 2;
    localparam int ARC_LC_LO_BIT    = 0;

    // writable masks; other positions are unimplemented, save the read-only fixed reference ready flag
    localparam logic [7:0] ARC_FR_WMASK  = 8'hBF;
    localparam logic [7:0] ARC_LC_WMASK  = 8'hBD;
    localparam logic [7:0] ARC_LL_WMASK  = 8'h1F;
    localparam logic [7:0] ARC_RST_BYTE  = 8'h00;

    // AXI responses
    localparam logic [1:0] ARC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ARC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ARC_GAIN_OFF,
        ARC_GAIN_1X,
        ARC_GAIN_2X,
        ARC_GAIN_4X
    } arc_gain_e;

    typedef enum logic [1:0] {
        ARC_SRC_SUPPLY,
        ARC_SRC_EXT_PIN,
        ARC_SRC_FIXED_BUF,
        ARC_SRC_RESERVED
    } arc_upper_e;

    // analog control bundle driven into the macros
    typedef struct packed {
        logic       fixed_ref_on;
        logic       temp_sense_on;
        logic       temp_range_high;
        logic [1:0] comparator_ref_gain;
        logic [1:0] converter_ref_gain;
        logic       ladder_on;
        logic       pin_one_drive;
        logic       pin_two_drive;
        logic [1:0] upper_source_sel;
        logic       lower_source_sel;
        logic [4:0] ladder_level;
    } arc_ctl_s;

endpackage

// ### src/arc_top.sv
/*
 * arc_top: AXI4-Lite register slave holding the fixed reference,
 * ladder control and ladder level registers, driving analog controls
 * and overriding the two ladder output pins.
 * Assumes one clock; pin inputs arrive asynchronously.
 */
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module arc_top
    import arc_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // write address channel
    input  wire logic [ARC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // write data channel
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // write response channel
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // read address channel
    input  wire logic [ARC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // read data channel
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // analog controls
    output var arc_ctl_s               ana_ctl,
    // ladder pins: digital side overrides
    input  wire logic                  pin_one_in,
    input  wire logic                  pin_two_in,
    input  wire logic                  pin_one_port_oe,
    input  wire logic                  pin_two_port_oe,
    input  wire logic                  pin_one_pullup_req,
    input  wire logic                  pin_two_pullup_req,
    output logic                       pin_one_oe,
    output logic                       pin_two_oe,
    output logic                       pin_one_pullup,
    output logic                       pin_two_pullup,
    output logic                       pin_one_in_en,
    output logic                       pin_two_in_en,
    output logic                       pin_one_read,
    output logic                       pin_two_read
);

    // register decode, shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [ARC_ADDR_W-1:0] a);
        logic [1:0] s;
        s = 2'h3;
        case (a)
            ARC_OFS_FIXED_REF:  s = 2'h0;
            ARC_OFS_LADDER_CTL: s = 2'h1;
            ARC_OFS_LADDER_LVL: s = 2'h2;
            default:            s = 2'h3;
        endcase
        return s;
    endfunction

    logic [7:0]            fr_q;
    logic [7:0]            lc_q;
    logic [7:0]            ll_q;
    logic [ARC_ADDR_W-1:0] awaddr_q;
    logic                  aw_have_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  w_have_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  rvalid_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;
    logic [1:0]            pin_one_sync_q;
    logic [1:0]            pin_two_sync_q;
    logic                  pin_one_rd_q;
    logic                  pin_two_rd_q;
    logic [5:0]            pin_ovr_q;

    // write path: address and data taken in either order
    wire        aw_take  = s_axi_awvalid && !aw_have_q && !bvalid_q;
    wire        w_take   = s_axi_wvalid && !w_have_q && !bvalid_q;
    wire        wr_fire  = aw_have_q && w_have_q && !bvalid_q;
    wire [1:0]  wr_sel   = reg_sel(awaddr_q);
    wire        wr_lane0 = wr_fire && wstrb_q[0];
    wire [7:0]  wr_byte  = wdata_q[7:0];

    // unimplemented bits masked at write time
    wire [7:0] fr_d = (wr_lane0 && wr_sel == 2'h0) ?
                      (wr_byte & ARC_FR_WMASK) : fr_q;
    wire [7:0] lc_d = (wr_lane0 && wr_sel == 2'h1) ?
                      (wr_byte & ARC_LC_WMASK) : lc_q;
    wire [7:0] ll_d = (wr_lane0 && wr_sel == 2'h2) ?
                      (wr_byte & ARC_LL_WMASK) : ll_q;

    // read path
    wire        ar_take = s_axi_arvalid && !rvalid_q;
    wire [1:0]  rd_sel  = reg_sel(s_axi_araddr);
    wire [7:0]  fr_rd   = fr_q | (8'h01 << ARC_FR_RDY_BIT);
    wire [7:0]  rd_byte = (rd_sel == 2'h0) ? fr_rd :
                          (rd_sel == 2'h1) ? lc_q :
                          (rd_sel == 2'h2) ? ll_q : ARC_RST_BYTE;

    // register-to-macro field mapping
    wire ladder_p1 = lc_q[ARC_LC_P1_BIT];
    wire ladder_p2 = lc_q[ARC_LC_P2_BIT];

    // control registers; only reset clears them, so a wake from
    // sleep (no reset) keeps contents
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fr_q <= ARC_RST_BYTE;
            lc_q <= ARC_RST_BYTE;
            ll_q <= ARC_RST_BYTE;
        end
        else
        begin
            fr_q <= fr_d;
            lc_q <= lc_d;
            ll_q <= ll_d;
        end
    end

    // write channel holding registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= ARC_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_sel == 2'h3) ? ARC_RESP_SLVERR
                                              : ARC_RESP_OKAY;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= ARC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= (rd_sel == 2'h3) ? ARC_RESP_SLVERR : ARC_RESP_OKAY;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // pin inputs pass two flops before use
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_one_sync_q <= 2'h0;
            pin_two_sync_q <= 2'h0;
        end
        else
        begin
            pin_one_sync_q <= {pin_one_sync_q[0], pin_one_in};
            pin_two_sync_q <= {pin_two_sync_q[0], pin_two_in};
        end
    end

    // override built from the next register value, so the digital
    // driver lets go at the same edge the analog switch closes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_ovr_q    <= 6'h00;
            pin_one_rd_q <= 1'b0;
            pin_two_rd_q <= 1'b0;
        end
        else
        begin
            pin_ovr_q <= {pin_one_port_oe && !lc_d[ARC_LC_P1_BIT],
                          pin_two_port_oe && !lc_d[ARC_LC_P2_BIT],
                          pin_one_pullup_req && !lc_d[ARC_LC_P1_BIT],
                          pin_two_pullup_req && !lc_d[ARC_LC_P2_BIT],
                          !lc_d[ARC_LC_P1_BIT],
                          !lc_d[ARC_LC_P2_BIT]};
            pin_one_rd_q <= pin_one_sync_q[1] && !lc_d[ARC_LC_P1_BIT];
            pin_two_rd_q <= pin_two_sync_q[1] && !lc_d[ARC_LC_P2_BIT];
        end
    end

    // bus outputs
    assign s_axi_awready = aw_take;
    assign s_axi_wready  = w_take;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ar_take;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // analog fields straight from register flops
    assign ana_ctl.fixed_ref_on        = fr_q[ARC_FR_ON_BIT];
    assign ana_ctl.temp_sense_on       = fr_q[ARC_FR_TS_BIT];
    assign ana_ctl.temp_range_high     = fr_q[ARC_FR_RNG_BIT];
    assign ana_ctl.comparator_ref_gain =
        fr_q[ARC_FR_CMP_LSB +: 2];
    assign ana_ctl.converter_ref_gain  =
        fr_q[ARC_FR_CNV_LSB +: 2];
    assign ana_ctl.ladder_on           = lc_q[ARC_LC_ON_BIT];
    assign ana_ctl.pin_one_drive       = ladder_p1;
    assign ana_ctl.pin_two_drive       = ladder_p2;
    assign ana_ctl.upper_source_sel    = lc_q[ARC_LC_UP_LSB +: 2];
    assign ana_ctl.lower_source_sel    = lc_q[ARC_LC_LO_BIT];
    assign ana_ctl.ladder_level        = ll_q[4:0];

    // digital pin controls; reads forced low when routed
    assign pin_one_oe     = pin_ovr_q[5];
    assign pin_two_oe     = pin_ovr_q[4];
    assign pin_one_pullup = pin_ovr_q[3];
    assign pin_two_pullup = pin_ovr_q[2];
    assign pin_one_in_en  = pin_ovr_q[1];
    assign pin_two_in_en  = pin_ovr_q[0];
    assign pin_one_read   = pin_one_rd_q;
    assign pin_two_read   = pin_two_rd_q;

    // ready flag reads one however enable is set
    rdy_reads_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take && rd_sel == 2'h0 |=> s_axi_rdata[ARC_FR_RDY_BIT])
        else $error("ready flag read back as zero");

    // write to fixed ref register lands on the enable line next edge
    fr_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wr_sel == 2'h0 |=>
        ana_ctl.fixed_ref_on == $past(wr_byte[ARC_FR_ON_BIT]) &&
        ana_ctl.temp_sense_on == $past(wr_byte[ARC_FR_TS_BIT]) &&
        ana_ctl.comparator_ref_gain == $past(wr_byte[3:2]))
        else $error("fixed reference write not applied");

    // unimplemented ladder bits stay zero
    lc_unimpl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lc_q & ~ARC_LC_WMASK) == 8'h00 &&
        (ll_q & ~ARC_LL_WMASK) == 8'h00)
        else $error("unimplemented bit became set");

    // level write reaches ladder taps
    level_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_lane0 && wr_sel == 2'h2 |=>
        ana_ctl.ladder_level == $past(wr_byte[4:0]))
        else $error("ladder level not updated");

    // reset clears ladder state
    reset_clear_a: assert property (@(posedge aclk)
        !aresetn |=> !ana_ctl.ladder_on && !ana_ctl.pin_one_drive &&
        !ana_ctl.pin_two_drive && ana_ctl.ladder_level == 5'h00)
        else $error("ladder not cleared by reset");

    // routed pin loses digital functions
    pin_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ladder_p1 ##1 ladder_p1 |->
        !pin_one_oe && !pin_one_pullup && !pin_one_in_en)
        else $error("pin one not overridden");

    // routed pin reads zero
    pin_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ladder_p2) && ladder_p2 |-> !pin_two_read)
        else $error("routed pin read not zero");

    // routed pin two loses digital functions
    pin_two_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ladder_p2 ##1 ladder_p2 |->
        !pin_two_oe && !pin_two_pullup && !pin_two_in_en)
        else $error("pin two not overridden");

    // routed pin one reads zero
    pin_one_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(ladder_p1) && ladder_p1 |-> !pin_one_read)
        else $error("routed pin one read not zero");

    // ladder control holds without a write
    lc_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !(wr_lane0 && wr_sel == 2'h1) |=> $stable(lc_q))
        else $error("ladder control changed without write");

endmodule

`default_nettype wire

// ### test/arc_analog_model.sv
/*
 * arc_analog_model: far side of the two ladder pins. Resolves each pin
 * level from ladder routing, the gated port driver and the pull-up.
 * Assumes the block's gated pin controls and analog control bundle.
 */
`timescale 1ns/10ps
`default_nettype none

module arc_analog_model
    import arc_pkg::*;
(
    // clock
    input  wire logic       aclk,
    // controls from the block
    input  wire arc_ctl_s   ctl,
    input  wire logic [1:0] oe,
    input  wire logic [1:0] pu,
    // digital port data
    input  wire logic [1:0] port_d,
    // resolved pin levels
    output logic [1:0]      pin
);
    logic [1:0] wob_q = 2'h1;
    logic [1:0] routed;

    // analog or floating pins carry no stable logic level
    always_ff @(posedge aclk)
        wob_q <= ~wob_q;

    // ladder voltage wins, then driver, then pull-up
    assign routed = {ctl.pin_two_drive, ctl.pin_one_drive};
    assign pin[0] = routed[0] ? wob_q[0] : oe[0] ? port_d[0] :
                    pu[0] ? 1'b1 : wob_q[0];
    assign pin[1] = routed[1] ? wob_q[1] : oe[1] ? port_d[1] :
                    pu[1] ? 1'b1 : wob_q[1];
endmodule

`default_nettype wire

// ### test/arc_top_tb.sv
/*
 * arc_top_tb: register and pin tests for the analog reference control
 * block over AXI4-Lite. Assumes one 10 MHz clock, sync active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_errors++; \
            $display("wrong value t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

module arc_top_tb
    import arc_pkg::*;
;
    logic        aclk;
    logic        aresetn = 1'b0;
    logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0;
    logic [31:0] wdata = '0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    arc_ctl_s    ana_ctl;
    logic [1:0]  port_oe = '0, pu_req = '0, port_d = '0, pin_lvl;
    logic [1:0]  oe, pu, in_en, rd_pin;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [7:0]  v;

    arc_top dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ana_ctl(ana_ctl),
        .pin_one_in(pin_lvl[0]), .pin_two_in(pin_lvl[1]),
        .pin_one_port_oe(port_oe[0]), .pin_two_port_oe(port_oe[1]),
        .pin_one_pullup_req(pu_req[0]), .pin_two_pullup_req(pu_req[1]),
        .pin_one_oe(oe[0]), .pin_two_oe(oe[1]),
        .pin_one_pullup(pu[0]), .pin_two_pullup(pu[1]),
        .pin_one_in_en(in_en[0]), .pin_two_in_en(in_en[1]),
        .pin_one_read(rd_pin[0]), .pin_two_read(rd_pin[1]));

    arc_analog_model pm_u (.aclk(aclk), .ctl(ana_ctl), .oe(oe), .pu(pu),
        .port_d(port_d), .pin(pin_lvl));

    // clock generation
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard, far above the under two hundred cycles the run needs
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic aw_t;
        logic w_t;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_t = 1'b0;
        w_t = 1'b0;
        while (!(aw_t && w_t))
        begin
            @(posedge aclk);
            if (awvalid && awready)
            begin
                aw_t = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_t = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] ed,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        `CHK(rdata, {24'h0, ed})
        `CHK(rresp, er)
    endtask

    // pin overrides settle after the input synchroniser
    task automatic pins(input logic [3:0] e1, input logic [3:0] e2);
        repeat (6) @(posedge aclk);
        `CHK({oe[0], pu[0], in_en[0], rd_pin[0]}, e1)
        `CHK({oe[1], pu[1], in_en[1], rd_pin[1]}, e2)
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(ana_ctl, arc_ctl_s'(0))
        rd(ARC_OFS_FIXED_REF, 8'h40, ARC_RESP_OKAY);
        rd(ARC_OFS_LADDER_CTL, 8'h00, ARC_RESP_OKAY);
        rd(ARC_OFS_LADDER_LVL, 8'h00, ARC_RESP_OKAY);
        // sensor toggled but no conversion is started here, so the
        // settling wait before converting is trivially kept
        // every gain code on both buffers, range and sensor toggled
        for (int g = 0; g < 4; g++)
        begin
            v = {2'b11, g[0], g[1], g[1:0], ~g[1:0]};
            wr(ARC_OFS_FIXED_REF, v, 4'h1, ARC_RESP_OKAY);
            `CHK(ana_ctl.fixed_ref_on, 1'b1)
            `CHK(ana_ctl.temp_sense_on, v[5])
            `CHK(ana_ctl.temp_range_high, v[4])
            `CHK(ana_ctl.comparator_ref_gain, v[3:2])
            `CHK(ana_ctl.converter_ref_gain, v[1:0])
            rd(ARC_OFS_FIXED_REF, v, ARC_RESP_OKAY);
        end
        wr(ARC_OFS_FIXED_REF, 8'h00, 4'h1, ARC_RESP_OKAY);
        `CHK(ana_ctl.fixed_ref_on, 1'b0)
        rd(ARC_OFS_FIXED_REF, 8'h40, ARC_RESP_OKAY);
        // every upper source code, unimplemented bits written as ones
        for (int g = 0; g < 4; g++)
        begin
            v = {4'hC, g[1:0], 1'b1, g[0]};
            wr(ARC_OFS_LADDER_CTL, v, 4'h1, ARC_RESP_OKAY);
            `CHK(ana_ctl.ladder_on, 1'b1)
            `CHK(ana_ctl.upper_source_sel, v[3:2])
            `CHK(ana_ctl.lower_source_sel, v[0])
            rd(ARC_OFS_LADDER_CTL, v & 8'hBD, ARC_RESP_OKAY);
        end
        wr(ARC_OFS_LADDER_LVL, 8'hFF, 4'h1, ARC_RESP_OKAY);
        `CHK(ana_ctl.ladder_level, 5'h1F)
        rd(ARC_OFS_LADDER_LVL, 8'h1F, ARC_RESP_OKAY);
        // byte lane off and unmapped offset leave state alone
        wr(ARC_OFS_LADDER_LVL, 8'h0A, 4'h0, ARC_RESP_OKAY);
        wr(4'hC, 8'h55, 4'h1, ARC_RESP_SLVERR);
        rd(4'hC, 8'h00, ARC_RESP_SLVERR);
        rd(ARC_OFS_LADDER_LVL, 8'h1F, ARC_RESP_OKAY);
        // pins unrouted: port driver and pull-up pass through
        port_oe <= 2'b01;
        pu_req  <= 2'b10;
        port_d  <= 2'b01;
        wr(ARC_OFS_LADDER_CTL, 8'h80, 4'h1, ARC_RESP_OKAY);
        pins(4'b1011, 4'b0111);
        // every driver and pull-up requested, so routing must mask all
        port_oe <= 2'b11;
        pu_req  <= 2'b11;
        wr(ARC_OFS_LADDER_CTL, 8'hB0, 4'h1, ARC_RESP_OKAY);
        `CHK({ana_ctl.pin_one_drive, ana_ctl.pin_two_drive}, 2'b11)
        pins(4'b0000, 4'b0000);
        wr(ARC_OFS_LADDER_CTL, 8'hA0, 4'h1, ARC_RESP_OKAY);
        pins(4'b0000, 4'b1110);
        // reset in mid-run clears ladder state and frees pins
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(ana_ctl.ladder_on, 1'b0)
        `CHK({ana_ctl.pin_one_drive, ana_ctl.pin_two_drive}, 2'b00)
        `CHK(ana_ctl.ladder_level, 5'h00)
        rd(ARC_OFS_LADDER_LVL, 8'h00, ARC_RESP_OKAY);
        pins(4'b1111, 4'b1110);
        wrap_up();
    end
endmodule

`default_nettype wire
